// File: hdl/sewp_status_protect.sv
`default_nettype none
module sewp_status_protect #(
  parameter int WRITE_CYCLES = sewp_pkg::WRITE_CYCLES  // self-timed write length in cycles
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire sewp_pkg::sewp_pins_t pins,
  output logic so,
  output logic so_oe,
  output logic busy,
  output logic [7:0] status_shadow,
  output sewp_pkg::sewp_array_wr_t array_wr
);

  // ==========================================================
  // elaboration checks
  if (WRITE_CYCLES < 1) begin : g_bad_cycles
    $error("WRITE_CYCLES must be at least one");
  end

  // ==========================================================
  // pin synchronisers
  sewp_pkg::sewp_pins_t pins_meta;   // first stage, read only by second
  sewp_pkg::sewp_pins_t pins_sync;   // second stage
  logic sck_prev;                    // delayed copy for edge finding
  logic cs_n_prev;                   // delayed copy for edge finding

  // two flops on every pin, then one more for edges
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pins_meta <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, hold_n: 1'b1, wp_n: 1'b1};
      pins_sync <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, hold_n: 1'b1, wp_n: 1'b1};
      sck_prev <= 1'b0;
      cs_n_prev <= 1'b1;
    end else begin
      pins_meta <= pins;
      pins_sync <= pins_meta;
      sck_prev <= pins_sync.sck;
      cs_n_prev <= pins_sync.cs_n;
    end
  end

  // ==========================================================
  // edge and qualifier decode
  wire selected = !pins_sync.cs_n;
  wire hold_active = !pins_sync.hold_n;
  // hold tied high leaves these edges untouched
  wire sck_ok = selected && !hold_active;
  wire sck_rise = sck_ok && pins_sync.sck && !sck_prev;
  wire sck_fall = sck_ok && !pins_sync.sck && sck_prev;
  wire cs_fall = !pins_sync.cs_n && cs_n_prev;
  wire cs_rise = pins_sync.cs_n && !cs_n_prev;
  wire wp_low = !pins_sync.wp_n;

  // ==========================================================
  // status storage
  logic wel;                  // write-enable latch
  logic [1:0] bp;             // {block_protect_hi, block_protect_lo}
  logic hw_protect_enable;                 // hw_protect_enable
  logic [1:0] bp_pending;     // values waiting for write end
  logic hw_protect_enable_pending;
  logic stat_wr_pending;      // status update due at write end
  logic [$clog2(WRITE_CYCLES+1)-1:0] wr_count; // remaining write cycles

  wire write_busy = (wr_count != '0);
  wire hw_protect = wp_low && hw_protect_enable;

  // readable status; reserved bits zero, all ones while writing
  wire [7:0] status_word = write_busy ? sewp_pkg::STATUS_BUSY_WORD :
      {hw_protect_enable, 3'h0, bp, wel, 1'b0};

  // ==========================================================
  // protection decode
  // lowest protected address test; nothing protected at level 0
  function automatic logic addr_protected(input logic [1:0] level, input logic [7:0] addr);
    case (level)
      sewp_pkg::BP_NONE: addr_protected = 1'b0;
      sewp_pkg::BP_QUARTER: addr_protected = (addr >= sewp_pkg::QUARTER_BASE);
      sewp_pkg::BP_HALF: addr_protected = (addr >= sewp_pkg::HALF_BASE);
      default: addr_protected = 1'b1;
    endcase
  endfunction : addr_protected

  // ==========================================================
  // serial engine state
  typedef enum {ST_OPCODE, ST_ADDR, ST_DATA, ST_STAT_OUT, ST_IGNORE} sewp_state_t;
  sewp_state_t state;
  logic [2:0] bit_cnt;        // bits taken in current byte
  logic [7:0] in_shift;       // bits so far, msb first
  logic [7:0] addr_reg;       // captured array address
  logic [7:0] data_reg;       // last full data byte
  logic data_seen;            // at least one full data byte
  sewp_pkg::sewp_cmd_t cmd;   // command in flight
  logic [2:0] out_cnt;        // status bit position counter
  logic [7:0] out_byte;       // status snapshot being sent

  wire [7:0] next_byte = {in_shift[6:0], pins_sync.si};
  wire byte_done = sck_rise && (bit_cnt == 3'h7);
  wire op_family = (next_byte[7:4] == sewp_pkg::OP_UPPER);
  wire [2:0] op_low = next_byte[2:0];
  wire is_set_wel = op_family && (op_low == sewp_pkg::OP_SET_WEL);
  wire is_clr_wel = op_family && (op_low == sewp_pkg::OP_CLR_WEL);
  wire is_stat_rd = op_family && (op_low == sewp_pkg::OP_STAT_RD);
  wire is_stat_wr = op_family && (op_low == sewp_pkg::OP_STAT_WR);
  wire is_arr_wr = op_family && (op_low == sewp_pkg::OP_ARRAY_WR);

  // ==========================================================
  // launch decisions at chip-select release
  // status write: latch set and not hardware protected
  wire stat_wr_go = cs_rise && (cmd == sewp_pkg::CMD_STAT_WR) && data_seen &&
      wel && !hw_protect && !write_busy;
  // array write: latch set and address outside the chosen blocks
  wire arr_wr_go = cs_rise && (cmd == sewp_pkg::CMD_ARRAY_WR) && data_seen &&
      wel && !addr_protected(bp, addr_reg) && !write_busy;
  // a set enable may not be cleared while the pin is low
  wire next_hw_protect_enable = (wp_low && hw_protect_enable) ? 1'b1 : data_reg[sewp_pkg::BIT_HW_PROTECT_ENABLE];
  wire [1:0] next_bp = {data_reg[sewp_pkg::BIT_BP_HI], data_reg[sewp_pkg::BIT_BP_LO]};

  // ==========================================================
  // instruction sequencer
  // hold freezes every counter here since no edge is qualified
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_OPCODE;
      bit_cnt <= 3'h0;
      in_shift <= 8'h00;
      addr_reg <= 8'h00;
      data_reg <= 8'h00;
      data_seen <= 1'b0;
      cmd <= sewp_pkg::CMD_NONE;
    end else if (cs_fall) begin
      // fresh instruction each time select drops
      state <= ST_OPCODE;
      bit_cnt <= 3'h0;
      data_seen <= 1'b0;
      cmd <= sewp_pkg::CMD_NONE;
    end else if (sck_rise) begin
      in_shift <= next_byte;
      bit_cnt <= bit_cnt + 3'h1;
      if (byte_done) begin
        case (state)
          ST_OPCODE: begin
            // busy device answers only the status read
            if (is_stat_rd) begin
              state <= ST_STAT_OUT;
            end else if (write_busy) begin
              state <= ST_IGNORE;
            end else if (is_set_wel) begin
              cmd <= sewp_pkg::CMD_SET_WEL;
              state <= ST_IGNORE;
            end else if (is_clr_wel) begin
              cmd <= sewp_pkg::CMD_CLR_WEL;
              state <= ST_IGNORE;
            end else if (is_stat_wr) begin
              cmd <= sewp_pkg::CMD_STAT_WR;
              state <= ST_DATA;
            end else if (is_arr_wr) begin
              cmd <= sewp_pkg::CMD_ARRAY_WR;
              state <= ST_ADDR;
            end else begin
              // reads and id page live elsewhere
              state <= ST_IGNORE;
            end
          end
          ST_ADDR: begin
            addr_reg <= next_byte;
            state <= ST_DATA;
          end
          ST_DATA: begin
            // only the last byte is kept; page buffering is elsewhere
            data_reg <= next_byte;
            data_seen <= 1'b1;
          end
          ST_STAT_OUT: state <= ST_STAT_OUT;
          ST_IGNORE: state <= ST_IGNORE;
          default: state <= ST_IGNORE;
        endcase
      end
    end
  end

  // ==========================================================
  // serial output, changed on falling edges only
  // output disabled while deselected or held
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      so <= 1'b0;
      so_oe <= 1'b0;
      out_cnt <= 3'h0;
      out_byte <= 8'h00;
    end else begin
      so_oe <= selected && !hold_active && (state == ST_STAT_OUT);
      if (cs_fall) begin
        out_cnt <= 3'h0;
      end else if (sck_fall && (state == ST_STAT_OUT)) begin
        out_cnt <= out_cnt + 3'h1;
        // fresh snapshot at each byte so polling sees the latest word
        if (out_cnt == 3'h0) begin
          out_byte <= status_word;
          so <= status_word[7];
        end else begin
          so <= out_byte[3'h7 - out_cnt];
        end
      end
    end
  end

  // ==========================================================
  // write cycle timer and status commit
  // trade-off: no array timing model, one fixed cycle length for both writes
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wel <= 1'b0;
      bp <= sewp_pkg::BP_RESET;
      hw_protect_enable <= sewp_pkg::HW_PROTECT_ENABLE_RESET;
      bp_pending <= sewp_pkg::BP_RESET;
      hw_protect_enable_pending <= sewp_pkg::HW_PROTECT_ENABLE_RESET;
      stat_wr_pending <= 1'b0;
      wr_count <= '0;
    end else begin
      if (stat_wr_go || arr_wr_go) begin
        wr_count <= WRITE_CYCLES[$bits(wr_count)-1:0];
        stat_wr_pending <= stat_wr_go;
        bp_pending <= next_bp;
        hw_protect_enable_pending <= next_hw_protect_enable;
      end else if (wr_count == {{($bits(wr_count)-1){1'b0}}, 1'b1}) begin
        // commit only when the cycle finishes
        wr_count <= '0;
        wel <= 1'b0;
        stat_wr_pending <= 1'b0;
        if (stat_wr_pending) begin
          bp <= bp_pending;
          hw_protect_enable <= hw_protect_enable_pending;
        end
      end else if (write_busy) begin
        wr_count <= wr_count - {{($bits(wr_count)-1){1'b0}}, 1'b1};
      end else if (cs_rise && (cmd == sewp_pkg::CMD_SET_WEL)) begin
        wel <= 1'b1;
      end else if (cs_rise && (cmd == sewp_pkg::CMD_CLR_WEL)) begin
        wel <= 1'b0;
      end
    end
  end

  // ==========================================================
  // registered outputs toward the array and system
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      array_wr <= '0;
      busy <= 1'b0;
      status_shadow <= 8'h00;
    end else begin
      array_wr.valid <= arr_wr_go;
      if (arr_wr_go) begin
        array_wr.addr <= addr_reg;
        array_wr.data <= data_reg;
      end
      busy <= write_busy;
      status_shadow <= status_word;
    end
  end

endmodule : sewp_status_protect
`default_nettype wire

// File: hdl/sewp_pkg.sv
`default_nettype none
package sewp_pkg;
  // ==========================================================
  // status register layout
  localparam int STATUS_W = 8;
  localparam int BIT_BUSY = 0;           // ready/busy flag
  localparam int BIT_WEL = 1;            // write-enable latch
  localparam int BIT_BP_LO = 2;          // block_protect_lo
  localparam int BIT_BP_HI = 3;          // block_protect_hi
  localparam int BIT_HW_PROTECT_ENABLE = 7;           // hw_protect_enable
  localparam logic [7:0] STATUS_BUSY_WORD = 8'hff; // every bit reads one while busy
  localparam logic [1:0] BP_RESET = 2'h0;          // shipped value of block protect
  localparam logic HW_PROTECT_ENABLE_RESET = 1'b0;

  // ==========================================================
  // opcodes, upper nibble zero, bit 3 don't care
  localparam logic [3:0] OP_UPPER = 4'h0;
  localparam logic [2:0] OP_SET_WEL = 3'h6;     // set_write_latch_cmd
  localparam logic [2:0] OP_CLR_WEL = 3'h4;     // clear_write_latch_cmd
  localparam logic [2:0] OP_STAT_RD = 3'h5;     // status_read_cmd
  localparam logic [2:0] OP_STAT_WR = 3'h1;     // status_write_cmd
  localparam logic [2:0] OP_ARRAY_WR = 3'h2;    // array write

  // ==========================================================
  // block protect ranges: lowest protected address per level
  localparam logic [1:0] BP_NONE = 2'h0;
  localparam logic [1:0] BP_QUARTER = 2'h1;
  localparam logic [1:0] BP_HALF = 2'h2;
  localparam logic [7:0] QUARTER_BASE = 8'hc0;
  localparam logic [7:0] HALF_BASE = 8'h80;

  // ==========================================================
  // timing: self-timed write cycle
  localparam int CLOCK_PERIOD_NS = 10;
  localparam int WRITE_TIME_NS = 4000000;
  localparam int WRITE_CYCLES = WRITE_TIME_NS / CLOCK_PERIOD_NS; // longest time, rounds down

  // ==========================================================
  // carriers
  typedef struct packed {
    logic cs_n;    // chip select, active low
    logic sck;     // serial clock
    logic si;      // serial data in
    logic hold_n;  // suspend, active low
    logic wp_n;    // write protect, active low
  } sewp_pins_t;

  typedef struct packed {
    logic valid;        // one-cycle write launch
    logic [7:0] addr;
    logic [7:0] data;
  } sewp_array_wr_t;

  // command pending at chip-select release
  typedef enum {CMD_NONE, CMD_SET_WEL, CMD_CLR_WEL, CMD_STAT_WR, CMD_ARRAY_WR} sewp_cmd_t;
endpackage : sewp_pkg
`default_nettype wire

// File: sim/sewp_master.sv
`default_nettype none
// ==========
// spi master model, mode 0 or 3, 8 clocks per sck period
module sewp_master (
  input wire logic clock,
  output sewp_pkg::sewp_pins_t pins,
  input wire logic so,
  input wire logic so_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  initial pins = '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, hold_n: 1'b1, wp_n: 1'b1};
  // idle clock level: low for mode 0, high for mode 3
  logic cpol = 1'b0;
  // idle si wanders so a stale bit never looks valid
  always @(posedge clock) begin
    if (pins.cs_n) pins.si <= ~pins.si;
  end
  // one framed transfer, msb first; h picks a bit to pause at
  task automatic xfer(input logic [31:0] d, input int n, input int h, output logic [31:0] q);
    q = '0;
    @(posedge clock);
    pins.cs_n <= 1'b0;
    @(posedge clock);
    for (int i = n - 1; i >= 0; i--) begin
      // mode 3 drops the clock first, so data changes while it is low
      if (cpol) pins.sck <= 1'b0;
      pins.si <= d[i];
      if (i == h) begin
        repeat (2) @(posedge clock);
        pins.hold_n <= 1'b0;
        repeat (4) @(posedge clock);
        pins.sck <= 1'b1; // clock pulse that must be ignored
        pins.si <= ~d[i];
        repeat (4) @(posedge clock);
        pins.sck <= 1'b0;
        pins.si <= d[i];
        repeat (4) @(posedge clock);
        pins.hold_n <= 1'b1;
      end
      repeat (4) @(posedge clock);
      pins.sck <= 1'b1;
      repeat (4) @(posedge clock);
      // undriven line reads inverted, never a lucky match
      q = {q[30:0], so_oe ? so : ~so};
      if (!cpol) pins.sck <= 1'b0;
    end
    repeat (4) @(posedge clock);
    pins.cs_n <= 1'b1;
    repeat (8) @(posedge clock);
  endtask : xfer
endmodule : sewp_master
`default_nettype wire

// File: sim/sewp_status_protect_chk.sv
`default_nettype none
// ==========
// port-level checker
module sewp_status_protect_chk #(
  parameter int WRITE_CYCLES = 20
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire sewp_pkg::sewp_pins_t pins,
  input wire logic so,
  input wire logic so_oe,
  input wire logic busy,
  input wire logic [7:0] status_shadow,
  input wire sewp_pkg::sewp_array_wr_t array_wr
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  int busy_len; // length of the running write cycle
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) busy_len <= 0;
    else busy_len <= busy ? busy_len + 1 : 0;
  end
  a_busy_len: assert property ($fell(busy) |->
    busy_len >= WRITE_CYCLES - 1 && busy_len <= WRITE_CYCLES + 1) else $error("write length");
  a_busy_word: assert property (busy && $past(busy) |->
    status_shadow == 8'hff) else $error("busy word");
  a_ready_bit: assert property (!busy && !$past(busy) |-> !status_shadow[0])
    else $error("ready bit");
  a_dont_care: assert property (!busy && !$past(busy) |-> status_shadow[6:4] == 3'h0)
    else $error("bits 4-6 not zero");
  a_oe_deselect: assert property (pins.cs_n [*6] |-> !so_oe) else $error("so driven");
  a_hold_quiet: assert property (!pins.hold_n [*6] |-> !so_oe) else $error("so in hold");
  a_wel_launch: assert property ($rose(busy) |-> $past(status_shadow[1]))
    else $error("write without latch");
  a_valid_pulse: assert property (array_wr.valid |=> !array_wr.valid) else $error("pulse");
  a_valid_busy: assert property (array_wr.valid |-> ##[0:2] busy) else $error("no cycle");
  a_valid_idle: assert property (array_wr.valid |-> !$past(busy, 2))
    else $error("write while busy");
  cover property ($rose(busy));
  cover property (array_wr.valid);
  cover property (!pins.hold_n && !pins.cs_n);
endmodule : sewp_status_protect_chk
bind sewp_status_protect sewp_status_protect_chk #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (
  .clock(clock), .arst_n(arst_n), .pins(pins), .so(so), .so_oe(so_oe), .busy(busy),
  .status_shadow(status_shadow), .array_wr(array_wr));
`default_nettype wire

// File: sim/sewp_status_protect_tb.sv
`default_nettype none
module sewp_status_protect_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int WC = 600; // long enough to read status mid-write
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  sewp_pkg::sewp_pins_t pins;
  logic so;
  logic so_oe;
  logic busy;
  logic [7:0] status_shadow;
  sewp_pkg::sewp_array_wr_t array_wr;
  int mismatches = 0;
  int n_compared = 0;
  int cycles = 0;
  int n_wr = 0; // launched array writes
  logic [15:0] last_wr;
  logic [31:0] rd;
  logic [7:0] v;
  logic [7:0] a;
  int n0;
  always #5 clock = ~clock;
  sewp_master m (.clock(clock), .pins(pins), .so(so), .so_oe(so_oe));
  sewp_status_protect #(.WRITE_CYCLES(WC)) dut (.clock(clock), .arst_n(arst_n),
    .pins(pins), .so(so), .so_oe(so_oe), .busy(busy), .status_shadow(status_shadow),
    .array_wr(array_wr));
  // ==========
  // monitors and timeout
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (array_wr.valid === 1'b1) begin
      n_wr <= n_wr + 1;
      last_wr <= {array_wr.addr, array_wr.data};
    end
    if (cycles == 80000) begin
      mismatches = mismatches + 1; // hang counts as a failure
      test_done();
    end
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic test_done();
    $display("mismatches %0d, compared %0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  // bench view of the protected ranges
  function automatic bit prot(input logic [1:0] b, input logic [7:0] ad);
    return b == 2'h3 || (b == 2'h2 && ad >= 8'h80) || (b == 2'h1 && ad >= 8'hc0);
  endfunction : prot
  task automatic status_read_cmd(input logic [7:0] exp, input int h);
    m.xfer(32'h0500, 16, h, rd);
    check("status", rd[7:0], exp);
  endtask : status_read_cmd
  task automatic wr_stat(input logic [7:0] d);
    m.xfer(32'h06, 8, -1, rd);
    m.xfer({16'h0, 8'h01, d}, 16, -1, rd);
  endtask : wr_stat
  // bounded wait for the write cycle to end
  task automatic settle();
    for (int i = 0; i < 2000 && busy !== 1'b0; i++) @(posedge clock);
    repeat (2) @(posedge clock);
  endtask : settle
  // ==========
  // main sequence
  initial begin
    rd = $urandom(32'he303b43b);
    repeat (6) @(posedge clock);
    arst_n <= 1'b1;
    repeat (4) @(posedge clock);
    status_read_cmd(8'h00, -1);
    wr_stat(8'h00);
    m.xfer(32'h04, 8, -1, rd);
    m.xfer(32'h018c, 16, -1, rd); // ignored, status write cycle still running
    m.xfer(32'h020010, 24, -1, rd);
    settle();
    status_read_cmd(8'h00, -1);
    check("wr_count", 32'(n_wr), 32'h0);
    m.xfer(32'h0e, 8, -1, rd); // don't-care bit 3 set
    status_read_cmd(8'h02, 5);
    m.xfer(32'h04, 8, -1, rd);
    status_read_cmd(8'h00, -1);
    // same latch sequence with the clock idling high
    m.cpol = 1'b1;
    m.pins.sck <= 1'b1;
    m.xfer(32'h06, 8, -1, rd);
    status_read_cmd(8'h02, 3);
    m.xfer(32'h04, 8, -1, rd);
    m.cpol = 1'b0;
    m.pins.sck <= 1'b0;
    status_read_cmd(8'h00, -1);
    v = 8'($urandom);
    wr_stat(v);
    status_read_cmd(8'hff, -1);
    m.xfer(32'h020000, 24, -1, rd); // must be ignored while busy
    // wait out the write before polling, so no torn ready word is read
    settle();
    check("wr_busy", 32'(n_wr), 32'h0);
    status_read_cmd({v[7], 3'h0, v[3:2], 2'h0}, -1);
    for (int lvl = 0; lvl < 4; lvl++) begin
      m.pins.wp_n <= 1'b1;
      wr_stat({1'b1, 3'($urandom), 2'(lvl), 2'($urandom)});
      settle();
      status_read_cmd({1'b1, 3'h0, 2'(lvl), 2'h0}, -1);
      m.pins.wp_n <= 1'b0;
      for (int k = 0; k < 4; k++) begin
        a = (lvl == 1) ? 8'hc0 : (lvl == 2) ? 8'h80 : 8'h00;
        a = (k == 0) ? a : (k == 1) ? a - 8'h01 : 8'($urandom);
        v = 8'($urandom);
        n0 = n_wr;
        m.xfer(32'h06, 8, -1, rd);
        m.xfer({8'h0, 8'h02, a, v}, 24, -1, rd);
        settle();
        check("wr_count", 32'(n_wr - n0), prot(2'(lvl), a) ? 32'h0 : 32'h1);
        if (!prot(2'(lvl), a)) check("wr_word", 32'(last_wr), {16'h0, a, v});
      end
      wr_stat(8'h00); // refused under hardware protection
      settle();
      // refused write leaves the latch set
      status_read_cmd({1'b1, 3'h0, 2'(lvl), 2'h2}, -1);
    end
    m.pins.wp_n <= 1'b1;
    wr_stat(8'h00);
    settle();
    status_read_cmd(8'h00, -1);
    test_done();
  end
endmodule : sewp_status_protect_tb
`default_nettype wire
